// [verilog/protect_lock_pkg.sv]
// Operation
// - Host selects, sends command 3Ch, then three address bytes inside the sector.
// - After the last address byte, status is driven every following clock.
// - Repeated byte reads 00h when unprotected and FFh when protected.
// - Releasing chip select ends the read and floats the output at once.
// - Chip select release is accepted at any bit of the status phase.
// - Returned status carries only the stored bit, never the pin level.
// - Sector outcome depends only on its stored bit, pin level ignored.
// - Hardware lock is active only with the pin low and the lock bit set.
// - Under hardware lock, sector and status writes are ignored entirely.
// - Clearing the lock bit never applies a global protect or unprotect.
// - With the pin held low a set lock bit stays until power cycles; here srst also clears it, pin low or not.
// - With the pin high the lock bit may still be set, a software lock.
// - Setting the lock bit from 0 also applies the global pattern.
// - With the lock bit 0 it may be set and protection stays changeable.
// - Software lock may be cleared by a status write, hardware lock not.
// - Summary field reports all, some or none of the sectors protected.
// - Status bits 5 to 2 all ones protect all, all zeros unprotect all.
package protect_lock_pkg;

   localparam int          SECTOR_COUNT     = 32;
   localparam int          SECTOR_BITS      = 5;
   localparam int          SECTOR_LSB       = 16;
   localparam int          FRAME_BITS       = 32;
   localparam int          CMD_MSB          = 31;
   localparam int          CMD_LSB          = 24;
   localparam logic [7:0]  CMD_READ_PROTECT = 8'h3C;
   localparam logic [5:0]  HEADER_BITS      = 6'h20;
   localparam int          LOCK_POS         = 7;
   localparam int          GLOBAL_MSB       = 5;
   localparam int          GLOBAL_LSB       = 2;
   localparam logic [3:0]  GLOBAL_PROTECT   = 4'hF;
   localparam logic [3:0]  GLOBAL_UNPROTECT = 4'h0;
   localparam logic [31:0] PROTECT_RESET    = 32'hFFFFFFFF;
   localparam logic        LOCK_RESET       = 1'b0;
   localparam logic [1:0]  SUMMARY_NONE     = 2'h0;
   localparam logic [1:0]  SUMMARY_SOME     = 2'h1;
   localparam logic [1:0]  SUMMARY_ALL      = 2'h3;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } status_write_s;

   typedef struct packed {
      logic                   valid;
      logic                   protect;
      logic [SECTOR_BITS-1:0] sector;
   } sector_cmd_s;

   typedef struct packed {
      logic       protection_regs_lock_bit;
      logic [1:0] protection_summary_field;
      logic       hw_locked;
      logic       sw_locked;
   } lock_status_s;

endpackage : protect_lock_pkg

// [verilog/sync_stage.sv]
`timescale 1ns/1ps
// Three-flop synchroniser; the output follows only once stages two and three agree.
module sync_stage #(
   parameter int         WIDTH = 1,
   parameter logic [0:0] INIT  = 1'b0
) (
   input  wire logic             clk,
   input  wire logic             arst,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] s1;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;

   always_ff @(posedge clk or posedge arst) begin
      if (arst) begin
         s1 <= {WIDTH{INIT}};
         s2 <= {WIDTH{INIT}};
         s3 <= {WIDTH{INIT}};
      end else begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
      end
   end

   always_ff @(posedge clk or posedge arst) begin
      if (arst) begin
         q <= {WIDTH{INIT}};
      end else if (s2 == s3) begin
         q <= s3;
      end
   end

endmodule : sync_stage

// [verilog/sector_protect_lock_logic.sv]
`timescale 1ns/1ps
module sector_protect_lock_logic
   import protect_lock_pkg::*;
(
   input  wire logic                    ref_clk,
   input  wire logic                    srst,
   input  wire logic                    wp_n_pin,
   input  wire logic                    sck,
   input  wire logic                    cs_n,
   input  wire logic                    mosi,
   output logic                         miso,
   output logic                         miso_oe,
   input  wire status_write_s           status_write,
   input  wire sector_cmd_s             sector_cmd,
   output logic [SECTOR_COUNT-1:0]      protect_bits,
   output lock_status_s                 lock_status,
   output logic                         write_ignored
);

   // Controller side, on ref_clk.
   logic                    wp_n_sync;
   logic                    wp_asserted;
   logic                    lock_bit;
   logic                    hw_lock;
   logic                    next_lock_bit;
   logic [3:0]              global_code;
   logic                    status_take;
   logic                    sector_take;
   logic [SECTOR_COUNT-1:0] ref_snapshot;
   logic                    snap_req;
   logic                    snap_ack_sync;

   // Link side, on sck.
   logic                    snap_req_link;
   logic                    snap_ack;
   logic [SECTOR_COUNT-1:0] link_snapshot;
   logic [5:0]              bit_cnt;
   logic [FRAME_BITS-2:0]   shift;
   logic [FRAME_BITS-1:0]   frame;
   logic                    read_active;
   logic                    read_value;

   sync_stage #(
      .WIDTH (1),
      .INIT  (1'b1)
   ) u_wp_sync (
      .clk  (ref_clk),
      .arst (1'b0),
      .d    (wp_n_pin),
      .q    (wp_n_sync)
   );

   sync_stage #(
      .WIDTH (1),
      .INIT  (1'b0)
   ) u_ack_sync (
      .clk  (ref_clk),
      .arst (srst),
      .d    (snap_ack),
      .q    (snap_ack_sync)
   );

   sync_stage #(
      .WIDTH (1),
      .INIT  (1'b0)
   ) u_req_sync (
      .clk  (sck),
      .arst (srst),
      .d    (snap_req),
      .q    (snap_req_link)
   );

   assign wp_asserted = ~wp_n_sync;
   assign hw_lock     = wp_asserted & lock_bit;
   assign global_code = status_write.data[GLOBAL_MSB:GLOBAL_LSB];

   // Any status write is dropped under the hardware lock.
   assign status_take = status_write.valid & ~hw_lock;
   // Sector commands need the lock bit clear, whatever the pin does.
   assign sector_take = sector_cmd.valid & ~lock_bit;

   always_comb begin
      next_lock_bit = lock_bit;
      if (status_take) begin
         next_lock_bit = status_write.data[LOCK_POS];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         lock_bit <= LOCK_RESET;
      end else begin
         lock_bit <= next_lock_bit;
      end
   end

   // The global pattern is applied only while the lock bit was clear before the write,
   // so a write that clears a software lock leaves the sectors alone.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         protect_bits <= PROTECT_RESET;
      end else begin
         if (sector_take) begin
            protect_bits[sector_cmd.sector] <= sector_cmd.protect;
         end
         if (status_take && !lock_bit) begin
            if (global_code == GLOBAL_PROTECT) begin
               protect_bits <= PROTECT_RESET;
            end else if (global_code == GLOBAL_UNPROTECT) begin
               protect_bits <= '0;
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         write_ignored <= 1'b0;
      end else begin
         write_ignored <= (status_write.valid & hw_lock) |
                          (sector_cmd.valid & lock_bit);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         lock_status <= '0;
      end else begin
         lock_status.protection_regs_lock_bit <= lock_bit;
         lock_status.hw_locked                <= hw_lock;
         lock_status.sw_locked                <= lock_bit & ~wp_asserted;
         if (&protect_bits) begin
            lock_status.protection_summary_field <= SUMMARY_ALL;
         end else if (protect_bits == '0) begin
            lock_status.protection_summary_field <= SUMMARY_NONE;
         end else begin
            lock_status.protection_summary_field <= SUMMARY_SOME;
         end
      end
   end

   // A new snapshot is offered only after the link side acknowledged the last one,
   // so the word it copies is stable. The serial clock stops between frames, so the
   // copy lands a few serial clocks into the next frame.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ref_snapshot <= PROTECT_RESET;
         snap_req     <= 1'b0;
      end else if ((snap_ack_sync == snap_req) && (ref_snapshot != protect_bits)) begin
         ref_snapshot <= protect_bits;
         snap_req     <= ~snap_req;
      end
   end

   always_ff @(posedge sck or posedge srst) begin
      if (srst) begin
         link_snapshot <= PROTECT_RESET;
         snap_ack      <= 1'b0;
      end else if (snap_req_link != snap_ack) begin
         link_snapshot <= ref_snapshot;
         snap_ack      <= snap_req_link;
      end
   end

   assign frame = {shift, mosi};

   // Header capture; chip select high clears the frame at any bit.
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         bit_cnt <= 6'h00;
         shift   <= '0;
      end else if (bit_cnt != HEADER_BITS) begin
         bit_cnt <= bit_cnt + 6'h01;
         shift   <= frame[FRAME_BITS-2:0];
      end
   end

   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         read_active <= 1'b0;
         read_value  <= 1'b0;
      end else if (bit_cnt == HEADER_BITS - 6'h01) begin
         read_active <= (frame[CMD_MSB:CMD_LSB] == CMD_READ_PROTECT);
         // Only the stored bit is looked up; the pin never enters here.
         read_value  <= link_snapshot[frame[SECTOR_LSB+SECTOR_BITS-1:SECTOR_LSB]];
      end
   end

   // Every bit of the byte equals the stored bit, so the output just holds it.
   always_ff @(negedge sck or posedge cs_n) begin
      if (cs_n) begin
         miso    <= 1'b0;
         miso_oe <= 1'b0;
      end else if (read_active) begin
         miso    <= read_value;
         miso_oe <= 1'b1;
      end
   end

endmodule : sector_protect_lock_logic

// [verification/sector_protect_lock_props.sv]
`timescale 1ns/1ps
module sector_protect_lock_props
   import protect_lock_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        srst,
   input wire logic        cs_n,
   input wire logic        miso,
   input wire logic        miso_oe,
   input wire status_write_s status_write,
   input wire sector_cmd_s sector_cmd,
   input wire logic [31:0] protect_bits,
   input wire lock_status_s lock_status,
   input wire logic        write_ignored
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   // Lock is read from the status view, so a write one cycle earlier may still hide in it.
   wire logic lk = lock_status.protection_regs_lock_bit;
   wire logic sw = status_write.valid;
   wire logic [3:0] gp = status_write.data[5:2];
   a_cs_float: assert property (cs_n && $past(cs_n) |-> !miso_oe)
      else $error("output enabled while deselected");
   a_miso_steady: assert property (miso_oe && $past(miso_oe) |-> miso == $past(miso))
      else $error("status bit changed within frame");
   a_sector_apply: assert property (sector_cmd.valid && !lk && !sw && !$past(sw) |=>
      protect_bits[$past(sector_cmd.sector)] == $past(sector_cmd.protect))
      else $error("sector request not applied");
   a_sector_refuse: assert property (sector_cmd.valid && lk && !sw && !$past(sw) |=>
      $stable(protect_bits) && write_ignored) else $error("locked sector request acted on");
   a_global_set: assert property (sw && !lk && !$past(sw) && gp == GLOBAL_PROTECT |=>
      protect_bits == PROTECT_RESET) else $error("global protect missed");
   a_unlock_keep: assert property (sw && lk && !$past(sw) |=> $stable(protect_bits))
      else $error("global pattern applied while locked");
   a_hw_hold: assert property (lock_status.hw_locked |=> lk)
      else $error("lock bit changed under hardware lock");
   a_summary_map: assert property (!$past(srst) |-> lock_status.protection_summary_field ==
      (&$past(protect_bits) ? SUMMARY_ALL : |$past(protect_bits) ? SUMMARY_SOME : SUMMARY_NONE))
      else $error("summary field wrong");
   c_read: cover property (miso_oe);
   c_hw_write: cover property (lock_status.hw_locked && sw);
   c_ignored: cover property (write_ignored);
endmodule : sector_protect_lock_props

bind sector_protect_lock_logic sector_protect_lock_props u_props (.ref_clk(ref_clk),
   .srst(srst), .cs_n(cs_n), .miso(miso), .miso_oe(miso_oe), .status_write(status_write),
   .sector_cmd(sector_cmd), .protect_bits(protect_bits), .lock_status(lock_status),
   .write_ignored(write_ignored));

// [verification/spi_host_model.sv]
`timescale 1ns/1ps
module spi_host_model (
   output logic      sck,
   output logic      cs_n,
   output logic      mosi,
   input  wire logic miso
);
   // Chip select starts low and rises once, so the frame logic sees a clearing edge.
   // A level set at time zero may race the design's processes and leave them unknown.
   initial begin
      sck = 1'b0;
      cs_n = 1'b0;
      mosi = 1'b0;
      #1 cs_n = 1'b1;
   end
   // The clock stands still between frames, as a real host may stop it.
   task automatic frame(input logic [31:0] hdr, input int nrd, output logic [15:0] rd);
      rd = 16'h0000;
      cs_n = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         mosi = hdr[i];
         #24 sck = 1'b1;
         #24 sck = 1'b0;
      end
      for (int i = 0; i < nrd; i++) begin
         mosi = ~mosi;
         #24 sck = 1'b1;
         rd = {rd[14:0], miso};
         #24 sck = 1'b0;
      end
      #24 cs_n = 1'b1;
      #24;
   endtask : frame
endmodule : spi_host_model

// [verification/sector_protect_lock_logic_test.sv]
`timescale 1ns/1ps
module sector_protect_lock_logic_test;
   import protect_lock_pkg::*;
   typedef struct packed {
      status_write_s sw;
      sector_cmd_s   sc;
      logic [31:0]   pb;
      logic          lk;
      logic          ig;
   } row_s;
   logic          ref_clk = 1'b0;
   logic          srst = 1'b0;
   logic          wp_n_pin = 1'b1;
   status_write_s status_write = '0;
   sector_cmd_s   sector_cmd = '0;
   wire logic     sck, cs_n, mosi, miso, miso_oe, write_ignored;
   wire logic [31:0] protect_bits;
   lock_status_s  lock_status;
   int            failures = 0;
   int            check_count = 0;
   logic [15:0]   rd;
   row_s rows [9] = '{'{9'h000, 7'h43, 32'hFFFFFFF7, 1'b0, 1'b0},
      '{9'h100, 7'h00, 32'h00000000, 1'b0, 1'b0}, '{9'h000, 7'h7F, 32'h80000000, 1'b0, 1'b0},
      '{9'h13C, 7'h00, 32'hFFFFFFFF, 1'b0, 1'b0}, '{9'h104, 7'h00, 32'hFFFFFFFF, 1'b0, 1'b0},
      '{9'h180, 7'h00, 32'h00000000, 1'b1, 1'b0}, '{9'h000, 7'h65, 32'h00000000, 1'b1, 1'b1},
      '{9'h13C, 7'h00, 32'h00000000, 1'b0, 1'b0}, '{9'h000, 7'h69, 32'h00000200, 1'b0, 1'b0}};
   always #2.5 ref_clk = ~ref_clk;
   sector_protect_lock_logic dut (.ref_clk(ref_clk), .srst(srst), .wp_n_pin(wp_n_pin),
      .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
      .status_write(status_write), .sector_cmd(sector_cmd), .protect_bits(protect_bits),
      .lock_status(lock_status), .write_ignored(write_ignored));
   spi_host_model host (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso));
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH %s expected %0h seen %0h", n, e, s);
      end
   endtask : chk
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out
   task automatic req(input row_s r);
      @(negedge ref_clk);
      status_write = r.sw;
      sector_cmd = r.sc;
      @(negedge ref_clk);
      status_write = '0;
      sector_cmd = '0;
      chk("protect_bits", protect_bits, r.pb);
      chk("ignored", write_ignored, r.ig);
      @(negedge ref_clk);
      chk("lock", lock_status.protection_regs_lock_bit, r.lk);
   endtask : req
   initial begin
      #200000;
      failures++;
      close_out();
   end
   initial begin
      // The rise must be an event, since the link side clears only on an edge of srst.
      #1 srst = 1'b1;
      repeat (8) @(negedge ref_clk);
      srst = 1'b0;
      foreach (rows[i]) begin
         req(rows[i]);
         $display("row %0d done", i);
      end
      wp_n_pin = 1'b0;
      repeat (8) @(negedge ref_clk);
      req('{9'h1BC, 7'h00, 32'hFFFFFFFF, 1'b1, 1'b0});
      chk("hw_locked", lock_status.hw_locked, 1'b1);
      chk("sw_off", lock_status.sw_locked, 1'b0);
      req('{9'h100, 7'h00, 32'hFFFFFFFF, 1'b1, 1'b1});
      req('{9'h000, 7'h45, 32'hFFFFFFFF, 1'b1, 1'b1});
      host.frame(32'h00000000, 8, rd);
      chk("other_cmd", rd, 16'h0000);
      host.frame(32'h3C1A0000, 16, rd);
      chk("read_set", rd[7:0], 8'hFF);
      chk("oe_off", miso_oe, 1'b0);
      $display("hardware lock test done");
      @(negedge ref_clk);
      srst = 1'b1;
      repeat (8) @(negedge ref_clk);
      srst = 1'b0;
      wp_n_pin = 1'b1;
      @(negedge ref_clk);
      chk("reset_bits", protect_bits, 32'hFFFFFFFF);
      chk("reset_lock", lock_status.protection_regs_lock_bit, 1'b0);
      repeat (8) @(negedge ref_clk);
      req('{9'h000, 7'h5A, 32'hFBFFFFFF, 1'b0, 1'b0});
      host.frame(32'h00000000, 8, rd);
      host.frame(32'h3C1AFFFF, 12, rd);
      chk("read_clear", rd[11:0], 12'h000);
      host.frame(32'h3C1B0000, 12, rd);
      chk("read_near", rd[11:0], 12'hFFF);
      chk("oe_end", miso_oe, 1'b0);
      req('{9'h180, 7'h00, 32'h00000000, 1'b1, 1'b0});
      chk("sw_locked", lock_status.sw_locked, 1'b1);
      chk("summary", lock_status.protection_summary_field, SUMMARY_NONE);
      $display("reset and read test done");
      close_out();
   end
endmodule : sector_protect_lock_logic_test
